// file: hw/tsic_trap_irq_ctrl.sv
// trap status and interrupt control registers behind an avalon-mm slave
//
// Contract
// - nesting disable blocks preemption of serviced interrupt
// - arithmetic trap flag at bit 4
// - address trap flag at bit 3
// - stack trap flag at bit 2
// - oscillator failure trap flag at bit 1
// - unused control one bits read zero
// - alternate vector select picks alternate table
// - status bit mirrors temporary interrupt disable
// - polarity one falling edge, zero rising
`timescale 1ns/1ps
module tsic_trap_irq_ctrl
  import tsic_pkg::*;
#(
  parameter int N_EXT = 3,
  parameter logic [15:0] VEC_BASE_STD = 16'h0004,
  parameter logic [15:0] VEC_BASE_ALT = 16'h0104
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // avalon-mm slave
  input wire logic [AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DW-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DW-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // core side
  input wire tsic_trap_s i_trap,
  input wire logic i_temp_irq_off,
  input wire logic [N_EXT-1:0] i_ext_irq,
  input wire tsic_prio_s i_prio,
  input wire logic [VEC_IDX_W-1:0] i_vec_index,
  output logic o_nesting_disable,
  output logic o_alt_vector_select,
  output logic [N_EXT-1:0] o_ext_irq_edge,
  output logic o_preempt_ok,
  output logic [15:0] o_vector_addr,
  output logic o_irq
);

  if (N_EXT < 1 || N_EXT > EXT_MAX) begin : g_chk
    $error("tsic_trap_irq_ctrl: N_EXT must be 1..3");
  end

  // clear and enable writes look at byte lane 0 only
  if (N_EV > 8) begin : g_chk_lane
    $error("tsic_trap_irq_ctrl: event bits must fit byte lane 0");
  end

  if (POS_TRAP_HI - POS_TRAP_LO + 1 != N_TRAP) begin : g_chk_trap
    $error("tsic_trap_irq_ctrl: trap field width must match N_TRAP");
  end

  if (POS_TRAP_HI > 7) begin : g_chk_trap_lane
    $error("tsic_trap_irq_ctrl: trap field must sit in byte lane 0");
  end

  if (POS_EDGE_POL_LO + EXT_MAX > 8) begin : g_chk_pol
    $error("tsic_trap_irq_ctrl: polarity field must sit in byte lane 0");
  end

  if (POS_NEST_DIS / 8 != 1 || POS_ALT_VEC / 8 != 1) begin : g_chk_hi
    $error("tsic_trap_irq_ctrl: upper control bits must sit in lane 1");
  end

  // slot offset is index times two and must stay inside 16 bits
  if (VEC_IDX_W > 15) begin : g_chk_vec
    $error("tsic_trap_irq_ctrl: vector index too wide");
  end

  if (RW > DW) begin : g_chk_rw
    $error("tsic_trap_irq_ctrl: register image wider than the bus");
  end

  // ---------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ---------------------------------------------------------------
  logic resp_q;
  logic [DW-1:0] rd_data_q;

  wire bus_req = i_avs_read | i_avs_write;
  wire bus_first = bus_req & ~resp_q;
  wire wr_fire = i_avs_write & resp_q;
  wire rd_capture = i_avs_read & ~resp_q;

  // the wait cycle lets read data come from a flop, not the decode path
  assign o_avs_waitrequest = bus_first;
  assign o_avs_readdata = rd_data_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= bus_first;
    end
  end

  // ---------------------------------------------------------------
  // address decode and byte lanes
  // ---------------------------------------------------------------
  wire [AW-1:0] word_addr = {i_avs_address[AW-1:2], 2'b00};
  wire sel_one = (word_addr == OFS_CTRL_ONE);
  wire sel_two = (word_addr == OFS_CTRL_TWO);
  wire sel_stat = (word_addr == OFS_IRQ_STATUS);
  wire sel_clr = (word_addr == OFS_IRQ_CLEAR);
  wire sel_en = (word_addr == OFS_IRQ_ENABLE);

  wire lane0 = i_avs_byteenable[0];
  wire lane1 = i_avs_byteenable[1];

  wire wr_one_lo = wr_fire & sel_one & lane0;
  wire wr_one_hi = wr_fire & sel_one & lane1;
  wire wr_two_lo = wr_fire & sel_two & lane0;
  wire wr_two_hi = wr_fire & sel_two & lane1;
  wire wr_clr_lo = wr_fire & sel_clr & lane0;
  wire wr_en_lo = wr_fire & sel_en & lane0;

  // ---------------------------------------------------------------
  // software-writable control bits and the read-only temporary disable mirror
  // ---------------------------------------------------------------
  logic nesting_disable;
  logic alt_vector_select;
  logic [EXT_MAX-1:0] ext_edge_polarity;
  logic [N_EV-1:0] irq_enable;
  logic temp_irq_off_status;

  wire [EXT_MAX-1:0] wd_pol =
    i_avs_writedata[POS_EDGE_POL_LO +: EXT_MAX];

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      nesting_disable <= RST_CTRL_ONE[POS_NEST_DIS];
    end else if (wr_one_hi) begin
      nesting_disable <= i_avs_writedata[POS_NEST_DIS];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      alt_vector_select <= RST_CTRL_TWO[POS_ALT_VEC];
    end else if (wr_two_hi) begin
      alt_vector_select <= i_avs_writedata[POS_ALT_VEC];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ext_edge_polarity <= RST_CTRL_TWO[POS_EDGE_POL_LO +: EXT_MAX];
    end else if (wr_two_lo) begin
      ext_edge_polarity <= wd_pol;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_enable <= RST_IRQ_ENABLE;
    end else if (wr_en_lo) begin
      irq_enable <= i_avs_writedata[N_EV-1:0];
    end
  end

  // read-only mirror of the core's temporary disable, one cycle late
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      temp_irq_off_status <= RST_CTRL_TWO[POS_TMP_OFF];
    end else begin
      temp_irq_off_status <= i_temp_irq_off;
    end
  end

  // ---------------------------------------------------------------
  // trap status flags
  // ---------------------------------------------------------------
  logic [N_TRAP-1:0] trap_flags;
  wire [N_TRAP-1:0] trap_set = i_trap;
  wire [N_TRAP-1:0] wd_trap =
    i_avs_writedata[POS_TRAP_HI:POS_TRAP_LO];
  // writing one leaves a flag alone; only a zero clears it
  wire [N_TRAP-1:0] trap_clr = {N_TRAP{wr_one_lo}} & ~wd_trap;

  // flag order arith, addr, stack, osc lands on bits 4..1
  tsic_sticky #(
    .W(N_TRAP)
  ) u_trap_flags (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_set(trap_set),
    .i_clr(trap_clr),
    .o_flags(trap_flags)
  );

  wire arith_trap_flag = trap_flags[3];
  wire addr_trap_flag = trap_flags[2];
  wire stack_trap_flag = trap_flags[1];
  wire osc_fail_trap_flag = trap_flags[0];

  // ---------------------------------------------------------------
  // external interrupt edge detection
  // ---------------------------------------------------------------
  logic [N_EXT-1:0] ext_edge;

  tsic_edge_detect #(
    .W(N_EXT)
  ) u_ext_edge (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_level(i_ext_irq),
    .i_fall_sel(ext_edge_polarity[N_EXT-1:0]),
    .o_edge(ext_edge)
  );

  assign o_ext_irq_edge = ext_edge;

  wire [EXT_MAX-1:0] ext_edge_full = EXT_MAX'(ext_edge);

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic [N_EV-1:0] irq_status;
  wire [N_EV-1:0] ev_set = {ext_edge_full, trap_set};
  wire [N_EV-1:0] ev_clr =
    {N_EV{wr_clr_lo}} & i_avs_writedata[N_EV-1:0];

  tsic_sticky #(
    .W(N_EV)
  ) u_irq_status (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_set(ev_set),
    .i_clr(ev_clr),
    .o_flags(irq_status)
  );

  assign o_irq = |(irq_status & irq_enable);

  // ---------------------------------------------------------------
  // register images and read mux
  // ---------------------------------------------------------------
  logic [RW-1:0] img_one;
  logic [RW-1:0] img_two;

  always_comb begin
    img_one = '0;
    img_one[POS_NEST_DIS] = nesting_disable;
    img_one[POS_TRAP_HI:POS_TRAP_LO] = {arith_trap_flag,
      addr_trap_flag, stack_trap_flag, osc_fail_trap_flag};
  end

  always_comb begin
    img_two = '0;
    img_two[POS_ALT_VEC] = alt_vector_select;
    img_two[POS_TMP_OFF] = temp_irq_off_status;
    img_two[POS_EDGE_POL_LO +: EXT_MAX] = ext_edge_polarity;
  end

  // clear register is write-only; unmapped words read zero
  wire [DW-1:0] rd_mux =
    sel_one ? DW'(img_one) :
    sel_two ? DW'(img_two) :
    sel_stat ? DW'(irq_status) :
    sel_en ? DW'(irq_enable) :
    '0;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_data_q <= '0;
    end else if (rd_capture) begin
      rd_data_q <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // core-facing control outputs
  // ---------------------------------------------------------------
  wire higher_prio = i_prio.req_prio > i_prio.cur_prio;
  // with nesting off nothing may interrupt a source in service
  wire next_preempt_ok =
    ~i_prio.in_service | (~nesting_disable & higher_prio);

  wire [15:0] vec_base = alt_vector_select ?
    VEC_BASE_ALT : VEC_BASE_STD;
  // vector slots are two address units apart
  wire [15:0] next_vector_addr =
    vec_base + 16'({i_vec_index, 1'b0});

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_preempt_ok <= 1'b0;
    end else begin
      o_preempt_ok <= next_preempt_ok;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_vector_addr <= '0;
    end else begin
      o_vector_addr <= next_vector_addr;
    end
  end

  assign o_nesting_disable = nesting_disable;
  assign o_alt_vector_select = alt_vector_select;

endmodule

// file: hw/tsic_pkg.sv
// shared constants and types for the trap status and interrupt control block
package tsic_pkg;

  // bus geometry
  localparam int AW = 5;
  localparam int DW = 32;
  localparam int RW = 16;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL_ONE = 5'h00;
  localparam logic [AW-1:0] OFS_CTRL_TWO = 5'h04;
  localparam logic [AW-1:0] OFS_IRQ_STATUS = 5'h08;
  localparam logic [AW-1:0] OFS_IRQ_CLEAR = 5'h0C;
  localparam logic [AW-1:0] OFS_IRQ_ENABLE = 5'h10;

  // interrupt_control_one fields
  localparam int POS_NEST_DIS = 15;
  localparam int POS_TRAP_LO = 1;
  localparam int POS_TRAP_HI = 4;

  // interrupt_control_two fields
  localparam int POS_ALT_VEC = 15;
  localparam int POS_TMP_OFF = 14;
  localparam int POS_EDGE_POL_LO = 0;

  // event bits of the status, clear and enable registers
  localparam int N_TRAP = 4;
  localparam int EXT_MAX = 3;
  localparam int N_EV = N_TRAP + EXT_MAX;
  localparam int EV_EXT_LO = N_TRAP;

  // reset values
  localparam logic [RW-1:0] RST_CTRL_ONE = 16'h0000;
  localparam logic [RW-1:0] RST_CTRL_TWO = 16'h0000;
  localparam logic [N_EV-1:0] RST_IRQ_ENABLE = 7'h00;

  // vector index and priority widths
  localparam int VEC_IDX_W = 7;
  localparam int PRIO_W = 4;

  // trap events from the core, order matches bits 4..1
  typedef struct packed {
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } tsic_trap_s;

  // preemption query from the core
  typedef struct packed {
    logic in_service;
    logic [PRIO_W-1:0] req_prio;
    logic [PRIO_W-1:0] cur_prio;
  } tsic_prio_s;

endpackage

// file: hw/tsic_sticky.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module tsic_sticky #(
  parameter int W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flags
);

  if (W < 1) begin : g_chk
    $error("tsic_sticky: W must be at least 1");
  end

  logic [W-1:0] next_flags;

  // a set landing with its clear keeps the flag
  assign next_flags = (o_flags & ~i_clr) | i_set;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_flags <= '0;
    end else begin
      o_flags <= next_flags;
    end
  end

endmodule

// file: hw/tsic_edge_detect.sv
// per-input edge detector with selectable polarity
`timescale 1ns/1ps
module tsic_edge_detect #(
  parameter int W = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [W-1:0] i_level,
  input wire logic [W-1:0] i_fall_sel,
  output logic [W-1:0] o_edge
);

  if (W < 1) begin : g_chk
    $error("tsic_edge_detect: W must be at least 1");
  end

  logic primed;

  // first cycle after reset only loads history, no false edge from a high pin
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  for (genvar g = 0; g < W; g++) begin : g_bit
    logic prev;
    wire rise = ~prev & i_level[g];
    wire fall = prev & ~i_level[g];
    // edges judged on the raw pin, so flipping polarity makes no edge
    wire hit = primed & (i_fall_sel[g] ? fall : rise);
    always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
        prev <= 1'b0;
        o_edge[g] <= 1'b0;
      end else begin
        prev <= i_level[g];
        o_edge[g] <= hit;
      end
    end
  end

endmodule

// file: sim/tsic_trap_irq_ctrl_asserts.sv
// concurrent checks on the trap status and interrupt control ports
`timescale 1ns/1ps
module tsic_trap_irq_ctrl_asserts
  import tsic_pkg::*;
#(
  parameter int N_EXT = 3,
  parameter logic [15:0] VEC_BASE_STD = 16'h0004,
  parameter logic [15:0] VEC_BASE_ALT = 16'h0104
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DW-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_temp_irq_off,
  input wire logic [N_EXT-1:0] i_ext_irq,
  input wire tsic_prio_s i_prio,
  input wire logic [VEC_IDX_W-1:0] i_vec_index,
  input wire logic o_nesting_disable,
  input wire logic o_alt_vector_select,
  input wire logic [N_EXT-1:0] o_ext_irq_edge,
  input wire logic o_preempt_ok,
  input wire logic [15:0] o_vector_addr,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire rd_done = i_avs_read && !o_avs_waitrequest;
  AST_ONE_WAIT: assert property (i_avs_read && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("wait longer than one cycle");
  AST_NEST_BLOCK: assert property (
    i_prio.in_service && o_nesting_disable |=> !o_preempt_ok)
    else $error("preemption allowed while nesting disabled");
  AST_PREEMPT: assert property (
    !o_nesting_disable && i_prio.req_prio > i_prio.cur_prio
    |=> o_preempt_ok) else $error("higher priority not allowed in");
  AST_IRQ_HOLD: assert property (o_irq && !i_avs_write |=> o_irq)
    else $error("interrupt dropped without software write");
  AST_VEC_SEL: assert property (1'b1 |=> o_vector_addr ==
    ($past(o_alt_vector_select) ? VEC_BASE_ALT : VEC_BASE_STD)
    + {$past(i_vec_index), 1'b0}) else $error("vector address wrong");
  AST_TMP_OFF: assert property (
    rd_done && i_avs_address == OFS_CTRL_TWO
    |-> o_avs_readdata[POS_TMP_OFF] == $past(i_temp_irq_off, 2))
    else $error("temporary disable status wrong");
  AST_UNUSED_ZERO: assert property (
    rd_done && i_avs_address == OFS_CTRL_ONE
    |-> (o_avs_readdata & 32'hFFFF_7FE1) == 32'h0000_0000)
    else $error("unused control bits not zero");
  AST_EDGE_CAUSE: assert property (
    o_ext_irq_edge != '0 |->
    (o_ext_irq_edge & ~($past(i_ext_irq) ^ $past(i_ext_irq, 2))) == '0)
    else $error("edge pulse without pin change");
  cover property (o_irq);
  cover property (o_ext_irq_edge != '0);
  cover property (i_prio.in_service && o_nesting_disable);
endmodule

bind tsic_trap_irq_ctrl tsic_trap_irq_ctrl_asserts #(.N_EXT(N_EXT),
  .VEC_BASE_STD(VEC_BASE_STD), .VEC_BASE_ALT(VEC_BASE_ALT)) tsic_chk_i (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_temp_irq_off(i_temp_irq_off),
  .i_ext_irq(i_ext_irq), .i_prio(i_prio), .i_vec_index(i_vec_index),
  .o_nesting_disable(o_nesting_disable),
  .o_alt_vector_select(o_alt_vector_select),
  .o_ext_irq_edge(o_ext_irq_edge), .o_preempt_ok(o_preempt_ok),
  .o_vector_addr(o_vector_addr), .o_irq(o_irq));

// file: sim/tsic_core_model.sv
// core-side model raising trap events and the temporary disable level
`timescale 1ns/1ps
module tsic_core_model
  import tsic_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire tsic_trap_s i_trap_req,
  input wire logic i_off_req,
  output tsic_trap_s o_trap,
  output logic o_temp_irq_off
);
  tsic_trap_s prev;
  // a held request still raises its event only once
  assign o_trap = i_trap_req & ~prev;
  always_ff @(posedge i_clk_sys) begin
    prev <= i_reset ? '0 : i_trap_req;
    o_temp_irq_off <= i_off_req & !i_reset;
  end
endmodule

// file: sim/trap_status_interrupt_control_tb_top.sv
// self-checking bench for the trap status and interrupt control block
`timescale 1ns/1ps
module trap_status_interrupt_control_tb_top
  import tsic_pkg::*;
;
  typedef struct packed {
    logic [AW-1:0] a;
    logic [DW-1:0] w;
    logic [DW-1:0] e;
  } tsic_row_s;
  localparam logic [15:0] VB_ALT = 16'h0104;
  localparam logic [15:0] VB_STD = 16'h0004;
  // per step: polarity selects, new pin levels, edges that must count
  localparam logic [2:0] POL[3] = '{3'h0, 3'h6, 3'h4};
  localparam logic [2:0] PIN[3] = '{3'h3, 3'h4, 3'h3};
  localparam logic [2:0] HIT[3] = '{3'h3, 3'h2, 3'h7};
  logic i_clk_sys = '0;
  logic i_reset = '1;
  logic i_avs_read = '0;
  logic i_avs_write = '0;
  logic [AW-1:0] i_avs_address = '0;
  logic [DW-1:0] i_avs_writedata = '0;
  logic [DW-1:0] o_avs_readdata;
  logic o_avs_waitrequest, o_nesting_disable, o_alt_vector_select;
  logic o_preempt_ok, o_irq, temp_off;
  logic off_req = '0;
  logic [2:0] i_ext_irq = '0;
  logic [2:0] o_ext_irq_edge;
  tsic_trap_s trap_req = '0;
  tsic_trap_s trap;
  tsic_prio_s i_prio = '0;
  logic [VEC_IDX_W-1:0] i_vec_index = '0;
  logic [15:0] o_vector_addr;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  tsic_row_s rows[6] = '{
    '{OFS_CTRL_ONE, 32'hFFFF_FFFF, 32'h0000_8000},
    '{OFS_CTRL_TWO, 32'hFFFF_FFFF, 32'h0000_8007},
    '{OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_007F},
    '{OFS_IRQ_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000},
    '{5'h14, 32'hFFFF_FFFF, 32'h0000_0000},
    '{OFS_CTRL_TWO, 32'h0000_0000, 32'h0000_0000}};

  tsic_trap_irq_ctrl #(.N_EXT(3), .VEC_BASE_ALT(VB_ALT)) tsic_trap_irq_ctrl_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_trap(trap),
    .i_temp_irq_off(temp_off), .i_ext_irq(i_ext_irq), .i_prio(i_prio),
    .i_vec_index(i_vec_index), .o_nesting_disable(o_nesting_disable),
    .o_alt_vector_select(o_alt_vector_select),
    .o_ext_irq_edge(o_ext_irq_edge), .o_preempt_ok(o_preempt_ok),
    .o_vector_addr(o_vector_addr), .o_irq(o_irq));
  tsic_core_model tsic_core_model_i (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_trap_req(trap_req), .i_off_req(off_req),
    .o_trap(trap), .o_temp_irq_off(temp_off));

  initial forever #10 i_clk_sys = ~i_clk_sys;

  task automatic test_done();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(string nm, logic [DW-1:0] e, logic [DW-1:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // waitrequest and readdata taken at the rising edge, before it acts
  task automatic bus(logic [AW-1:0] a, logic w, logic [DW-1:0] d,
      output logic [DW-1:0] q);
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= '0;
    i_avs_read <= '0;
  endtask
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    logic [DW-1:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
    logic [DW-1:0] q;
    bus(a, 1'b0, '0, q);
    chk("readdata", e, q);
  endtask
  task automatic settle();
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic fire(int i);
    @(posedge i_clk_sys);
    trap_req <= tsic_trap_s'(4'h1 << i);
    @(posedge i_clk_sys);
    trap_req <= '0;
  endtask

  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_reset <= '0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    i_prio <= '{1'b1, 4'h5, 4'h3};
    settle();
    chk("preempt_ok", '0, DW'(o_preempt_ok));
    wr(OFS_CTRL_ONE, '0);
    settle();
    chk("preempt_ok", 32'h1, DW'(o_preempt_ok));
    wr(OFS_CTRL_TWO, 32'h0000_8000);
    i_vec_index <= 7'h05;
    off_req <= '1;
    settle();
    chk("vector_addr", DW'(VB_ALT + 16'h000A), DW'(o_vector_addr));
    rd(OFS_CTRL_TWO, 32'h0000_C000);
    off_req <= '0;
    // pin 0 sees counted rises and an ignored fall, pin 1 only counted edges, pin 2 an ignored rise and a counted fall
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL_TWO, DW'(POL[k]));
      i_ext_irq <= PIN[k];
      settle();
      rd(OFS_IRQ_STATUS, DW'(HIT[k]) << 4);
      wr(OFS_IRQ_CLEAR, 32'h0000_0070);
    end
    chk("vector_addr", DW'(VB_STD + 16'h000A), DW'(o_vector_addr));
    for (int i = 0; i < N_TRAP; i++) begin
      fire(i);
      rd(OFS_CTRL_ONE, 32'h2 << i);
      wr(OFS_CTRL_ONE, 32'h0000_001E);
      rd(OFS_CTRL_ONE, 32'h2 << i);
      wr(OFS_CTRL_ONE, '0);
      rd(OFS_CTRL_ONE, '0);
      rd(OFS_IRQ_STATUS, 32'h1 << i);
      chk("irq", 32'h1, DW'(o_irq));
      wr(OFS_IRQ_CLEAR, 32'h1 << i);
      settle();
      chk("irq", '0, DW'(o_irq));
    end
    wr(OFS_IRQ_ENABLE, '0);
    fire(0);
    settle();
    chk("irq", '0, DW'(o_irq));
    wr(OFS_IRQ_ENABLE, 32'h1);
    settle();
    chk("irq", 32'h1, DW'(o_irq));
    wr(OFS_CTRL_ONE, 32'h0000_8000);
    wr(OFS_CTRL_TWO, 32'h0000_8000);
    i_prio <= '0;
    i_ext_irq <= 3'h7;
    settle();
    chk("nesting_disable", 32'h1, DW'(o_nesting_disable));
    chk("alt_vector_select", 32'h1, DW'(o_alt_vector_select));
    chk("preempt_ok", 32'h1, DW'(o_preempt_ok));
    @(posedge i_clk_sys);
    i_reset <= '1;
    repeat (5) @(posedge i_clk_sys);
    chk("irq", '0, DW'(o_irq));
    chk("preempt_ok", '0, DW'(o_preempt_ok));
    chk("vector_addr", '0, DW'(o_vector_addr));
    chk("alt_vector_select", '0, DW'(o_alt_vector_select));
    chk("nesting_disable", '0, DW'(o_nesting_disable));
    i_reset <= '0;
    // pins stay high across release: status is read last, no edge
    rd(OFS_IRQ_ENABLE, '0);
    rd(OFS_CTRL_TWO, '0);
    rd(OFS_CTRL_ONE, '0);
    rd(OFS_IRQ_STATUS, '0);
    test_done();
  end
endmodule
